// ===== src/pirms_pkg.sv
package pirms_pkg;

  // bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // register indices; byte address is four times the index
  localparam int IDX_ENABLE = 'h100;
  localparam int IDX_SC0 = 'h102;
  localparam int IDX_SC1 = 'h103;
  localparam int IDX_CONV = 'h10E;
  localparam logic [ADDR_W-1:0] ADDR_ENABLE = ADDR_W'(IDX_ENABLE * 4);
  localparam logic [ADDR_W-1:0] ADDR_SC0 = ADDR_W'(IDX_SC0 * 4);
  localparam logic [ADDR_W-1:0] ADDR_SC1 = ADDR_W'(IDX_SC1 * 4);
  localparam logic [ADDR_W-1:0] ADDR_CONV = ADDR_W'(IDX_CONV * 4);

  // motion_status_and_mode fields
  localparam int SC0_EXT_HI = 7;
  localparam int SC0_EXT_LO = 6;
  localparam int SC0_DIS = 5;
  localparam int SC0_HOLD = 4;
  localparam int SC0_DMODE = 3;
  localparam int SC0_DIR = 2;
  localparam int SC0_MOT = 1;
  localparam int SC0_STAB = 0;

  // engine_config_and_tick fields
  localparam int SC1_TICK = 7;
  localparam int SC1_FRQ_HI = 6;
  localparam int SC1_FRQ_LO = 3;
  localparam int SC1_RATE = 2;
  localparam int SC1_RSVD = 1;
  localparam int SC1_DUAL = 0;
  localparam int CONV_GO = 0;

  // codes and reset values
  localparam logic [7:0] ENGINE_ON_CODE = 8'h11;
  localparam logic [7:0] ENGINE_OFF_CODE = 8'h00;
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [3:0] FREQ_MAX = 4'hC;
  localparam logic [3:0] FREQ_RST = 4'h0;
  localparam logic [1:0] EXT_RST = 2'h0;

  // timing
  localparam int CLK_KHZ = 250000;
  localparam int NORM_CLKS = 256;
  localparam int LOW_CLKS = 5129;
  localparam int BLANK_MS = 200;
  localparam int BLANK_CLKS = BLANK_MS * CLK_KHZ;
  localparam int CNT_W = 13;
  localparam int BLANK_W = 26;

  // converter pacing states, gray along run/idle/convert
  typedef enum logic [1:0] {
    PACE_RUN = 2'h0,
    PACE_IDLE = 2'h1,
    PACE_CONV = 2'h3
  } pirms_pace_e;

  // engine states, gray along off/run/hold
  typedef enum logic [1:0] {
    ENG_OFF = 2'h0,
    ENG_RUN = 2'h1,
    ENG_HOLD = 2'h3
  } pirms_eng_e;

endpackage

// ===== src/pirms_pace_if.sv
`timescale 1ns/1ps
interface pirms_pace_if;
  logic low_rate;
  logic start_req;
  logic sample_done;
  logic busy;
  logic adc_power;

  modport engine (
    output low_rate,
    output start_req,
    input sample_done,
    input busy,
    input adc_power
  );

  modport pacer (
    input low_rate,
    input start_req,
    output sample_done,
    output busy,
    output adc_power
  );
endinterface

// ===== src/pirms_pacer.sv
`timescale 1ns/1ps
module pirms_pacer
  import pirms_pkg::*;
#(
  parameter int CONV_CLKS = LOW_CLKS
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // engine side
  pirms_pace_if.pacer pif
);

  typedef struct packed {
    pirms_pace_e st;
    logic [CNT_W-1:0] cnt;
    logic done;
    logic power;
  } pirms_pacer_s;

  pirms_pacer_s r_reg;
  pirms_pacer_s r_next;

  // continuous or single-shot conversion pacing
  always_comb
  begin
    r_next = r_reg;
    r_next.done = 1'b0;
    unique case (r_reg.st)
      PACE_RUN:
      begin
        if (pif.low_rate)
        begin
          r_next.st = PACE_IDLE;
          r_next.cnt = '0;
        end
        else if (r_reg.cnt == CNT_W'(NORM_CLKS - 1))
        begin
          r_next.cnt = '0;
          r_next.done = 1'b1;
        end
        else
          r_next.cnt = r_reg.cnt + 1'b1;
      end
      PACE_IDLE:
      begin
        if (!pif.low_rate)
          r_next.st = PACE_RUN;
        else if (pif.start_req)
        begin
          r_next.st = PACE_CONV;
          r_next.cnt = '0;
        end
      end
      PACE_CONV:
      begin
        if (r_reg.cnt == CNT_W'(CONV_CLKS - 1))
        begin
          r_next.st = PACE_IDLE;
          r_next.done = 1'b1;
        end
        else
          r_next.cnt = r_reg.cnt + 1'b1;
      end
      default:
        r_next.st = PACE_RUN;
    endcase
    // converter off between single shots
    r_next.power = (r_next.st != PACE_IDLE);
  end

  // state register
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      r_reg <= '{st: PACE_RUN, cnt: '0, done: 1'b0, power: 1'b1};
    else
      r_reg <= r_next;
  end

  assign pif.sample_done = r_reg.done;
  assign pif.busy = (r_reg.st == PACE_CONV);
  assign pif.adc_power = r_reg.power;

endmodule

// ===== src/pirms_blank_timer.sv
`timescale 1ns/1ps
module pirms_blank_timer
  import pirms_pkg::*;
#(
  parameter int HOLD_CLKS = BLANK_CLKS
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // control
  input wire logic start_in,
  output logic active_out
);

  typedef struct packed {
    logic [BLANK_W-1:0] cnt;
    logic active;
  } pirms_blank_s;

  pirms_blank_s r_reg;
  pirms_blank_s r_next;

  // one-shot window of HOLD_CLKS cycles, restartable
  always_comb
  begin
    r_next = r_reg;
    if (start_in)
    begin
      r_next.cnt = BLANK_W'(HOLD_CLKS - 1);
      r_next.active = 1'b1;
    end
    else if (r_reg.active)
    begin
      if (r_reg.cnt == '0)
        r_next.active = 1'b0;
      else
        r_next.cnt = r_reg.cnt - 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      r_reg <= '{cnt: '0, active: 1'b0};
    else
      r_reg <= r_next;
  end

  assign active_out = r_reg.active;

endmodule

// ===== src/pirms_top.sv
`timescale 1ns/1ps
module pirms_top
  import pirms_pkg::*;
#(
  parameter int CONV_CLKS = LOW_CLKS,
  parameter int HOLD_CLKS = BLANK_CLKS
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [DATA_W-1:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [DATA_W-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // detector front end
  input wire logic motion_a_in,
  input wire logic motion_b_in,
  input wire logic motion_dir_in,
  input wire logic offset_settled_in,
  // engine controls
  output logic sample_strobe_out,
  output logic housekeep_out,
  output logic detect_active_out,
  output logic [1:0] ext_level_out,
  output logic [1:0] range_weight_out,
  output logic [3:0] freq_resp_out,
  output logic dual_pyro_out,
  output logic dir_mode_out,
  output logic low_rate_out,
  output logic emc_immune_out,
  output logic adc_power_out
);

  typedef struct packed {
    logic waitreq;
    logic [7:0] rdata;
    logic [7:0] en_code;
    pirms_eng_e st;
    logic [1:0] ext;
    logic hold;
    logic dir_mode;
    logic dir;
    logic motion;
    logic stable;
    logic tick;
    logic [3:0] freq;
    logic low_rate;
    logic dual;
    logic hk;
    logic strobe;
    logic conv_go;
    logic blank_go;
    logic armed;
    logic power;
    logic [1:0] rw;
    logic emc;
  } pirms_top_s;

  localparam pirms_top_s TOP_RST = '{
    waitreq: 1'b1, rdata: 8'h00, en_code: ENABLE_RST, st: ENG_OFF,
    ext: EXT_RST, hold: 1'b0, dir_mode: 1'b0, dir: 1'b0, motion: 1'b0,
    stable: 1'b0, tick: 1'b0, freq: FREQ_RST, low_rate: 1'b0,
    dual: 1'b0, hk: 1'b0, strobe: 1'b0, conv_go: 1'b0,
    blank_go: 1'b0, armed: 1'b0, power: 1'b1, rw: ~EXT_RST, emc: 1'b1};

  ////////////////////////////////////////////////////////////////////////
  // reset release

  logic [1:0] rst_sync_reg;
  logic rst_n;

  // two-stage release of the external reset
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end

  assign rst_n = rst_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////
  // submodules

  pirms_pace_if pace ();
  logic blank_active;
  pirms_top_s r_reg;
  pirms_top_s r_next;

  pirms_pacer #(.CONV_CLKS(CONV_CLKS)) u_pacer (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .pif(pace.pacer)
  );

  pirms_blank_timer #(.HOLD_CLKS(HOLD_CLKS)) u_blank (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .start_in(r_reg.blank_go),
    .active_out(blank_active)
  );

  // pacing requests from registered state
  assign pace.low_rate = r_reg.low_rate;
  assign pace.start_req = r_reg.conv_go;

  ////////////////////////////////////////////////////////////////////////
  // bus decode

  logic bus_req;
  logic bus_done;
  logic wr_en;
  logic [7:0] wd;
  logic wr_sc0;
  logic wr_sc1;
  logic [7:0] sc0_view;
  logic [7:0] sc1_view;
  logic svc;
  logic evt;

  // transfer completes on the cycle waitrequest is low
  assign bus_req = avs_read_in | avs_write_in;
  assign bus_done = bus_req & ~r_reg.waitreq;
  assign wr_en = avs_write_in & ~r_reg.waitreq & avs_byteenable_in[0];
  assign wd = avs_writedata_in[7:0];
  assign wr_sc0 = wr_en & (avs_address_in == ADDR_SC0);
  assign wr_sc1 = wr_en & (avs_address_in == ADDR_SC1);
  assign svc = pace.sample_done;
  // either sensor raises an event in dual mode
  assign evt = motion_a_in | (r_reg.dual & motion_b_in);

  // readable images of the two status/control registers
  always_comb
  begin
    sc0_view = 8'h00;
    sc0_view[SC0_EXT_HI:SC0_EXT_LO] = r_reg.ext;
    sc0_view[SC0_DIS] = (r_reg.st == ENG_OFF);
    sc0_view[SC0_HOLD] = r_reg.hold;
    sc0_view[SC0_DMODE] = r_reg.dir_mode;
    sc0_view[SC0_DIR] = r_reg.dir;
    sc0_view[SC0_MOT] = r_reg.motion;
    sc0_view[SC0_STAB] = r_reg.stable;
    sc1_view = 8'h00;
    sc1_view[SC1_TICK] = r_reg.tick;
    sc1_view[SC1_FRQ_HI:SC1_FRQ_LO] = r_reg.freq;
    sc1_view[SC1_RATE] = r_reg.low_rate;
    sc1_view[SC1_DUAL] = r_reg.dual;
  end

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    r_next = r_reg;
    r_next.hk = 1'b0;
    r_next.strobe = svc;
    r_next.conv_go = 1'b0;
    r_next.blank_go = 1'b0;
    // one wait cycle, then the answer
    r_next.waitreq = ~(bus_req & r_reg.waitreq);
    if (avs_read_in & r_reg.waitreq)
    begin
      unique case (avs_address_in)
        ADDR_ENABLE: r_next.rdata = r_reg.en_code;
        ADDR_SC0: r_next.rdata = sc0_view;
        ADDR_SC1: r_next.rdata = sc1_view;
        ADDR_CONV: r_next.rdata = {7'h00, pace.busy};
        default: r_next.rdata = 8'h00;
      endcase
    end

    // engine work happens on each sample service
    if (svc)
    begin
      unique case (r_reg.st)
        ENG_OFF:
        begin
          if (r_reg.en_code == ENGINE_ON_CODE)
          begin
            r_next.st = r_reg.hold ? ENG_HOLD : ENG_RUN;
            r_next.stable = 1'b0;
          end
        end
        ENG_RUN, ENG_HOLD:
        begin
          if (r_reg.en_code == ENGINE_OFF_CODE)
          begin
            r_next.st = ENG_OFF;
            r_next.stable = 1'b0;
          end
          else
          begin
            r_next.st = r_reg.hold ? ENG_HOLD : ENG_RUN;
            if (offset_settled_in)
              r_next.stable = 1'b1;
            if (r_reg.tick)
            begin
              r_next.tick = 1'b0;
              r_next.hk = 1'b1;
            end
          end
        end
      endcase
    end

    // software writes; a software set of the tick beats the engine clear
    if (wr_en & (avs_address_in == ADDR_ENABLE))
      r_next.en_code = wd;
    if (wr_sc0)
    begin
      r_next.ext = wd[SC0_EXT_HI:SC0_EXT_LO];
      r_next.hold = wd[SC0_HOLD];
      r_next.dir_mode = wd[SC0_DMODE];
      if (!wd[SC0_MOT])
        r_next.motion = 1'b0;
    end
    if (wr_sc1)
    begin
      if (wd[SC1_TICK])
        r_next.tick = 1'b1;
      // out-of-range codes saturate at the top value
      if (wd[SC1_FRQ_HI:SC1_FRQ_LO] > FREQ_MAX)
        r_next.freq = FREQ_MAX;
      else
        r_next.freq = wd[SC1_FRQ_HI:SC1_FRQ_LO];
      r_next.low_rate = wd[SC1_RATE];
      r_next.dual = wd[SC1_DUAL];
      if ((r_reg.st != ENG_OFF) && (wd[SC1_RATE] != r_reg.low_rate))
        r_next.blank_go = 1'b1;
    end
    if (wr_en & (avs_address_in == ADDR_CONV) & wd[CONV_GO])
      r_next.conv_go = 1'b1;

    // motion set wins over a same-cycle software clear
    if (svc & r_reg.armed & evt & (~r_reg.motion | (wr_sc0 & ~wd[SC0_MOT])))
    begin
      r_next.motion = 1'b1;
      r_next.dir = r_reg.dir_mode ? motion_dir_in : 1'b0;
    end

    // detection only when running, settled and not blanked
    r_next.armed = (r_next.st == ENG_RUN) & r_next.stable
      & ~blank_active & ~r_reg.blank_go & ~r_next.blank_go;
    r_next.power = pace.adc_power;
    // range influence falls with level; immunity only at normal rate
    r_next.rw = ~r_next.ext;
    r_next.emc = ~r_next.low_rate;
  end

  // state register
  always_ff @(posedge clk_in or negedge rst_n)
  begin
    if (!rst_n)
      r_reg <= TOP_RST;
    else
      r_reg <= r_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign avs_readdata_out = {24'h00_0000, r_reg.rdata};
  assign avs_waitrequest_out = r_reg.waitreq;
  assign sample_strobe_out = r_reg.strobe;
  assign housekeep_out = r_reg.hk;
  assign detect_active_out = r_reg.armed;
  assign ext_level_out = r_reg.ext;
  assign range_weight_out = r_reg.rw;
  assign freq_resp_out = r_reg.freq;
  assign dual_pyro_out = r_reg.dual;
  assign dir_mode_out = r_reg.dir_mode;
  assign low_rate_out = r_reg.low_rate;
  assign emc_immune_out = r_reg.emc;
  assign adc_power_out = r_reg.power;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking dcb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n);

  sequence tick_seen;
    svc && (r_reg.st != ENG_OFF) && r_reg.tick
      && (r_reg.en_code != ENGINE_OFF_CODE) && !wr_sc1;
  endsequence

  sequence rate_flip;
    wr_sc1 && (r_reg.st != ENG_OFF)
      && (wd[SC1_RATE] != r_reg.low_rate);
  endsequence

  a_disable_ack: assert property (
    svc && (r_reg.st != ENG_OFF) && (r_reg.en_code == ENGINE_OFF_CODE)
      |=> (r_reg.st == ENG_OFF) && sc0_view[SC0_DIS])
    else $error("engine did not acknowledge disable");

  a_enable_ack: assert property (
    svc && (r_reg.st == ENG_OFF) && (r_reg.en_code == ENGINE_ON_CODE)
      |=> !sc0_view[SC0_DIS] && !r_reg.stable)
    else $error("engine did not acknowledge enable");

  a_hold_exit: assert property (
    svc && (r_reg.st == ENG_HOLD) && !r_reg.hold
      && (r_reg.en_code != ENGINE_OFF_CODE)
      |=> r_reg.st == ENG_RUN)
    else $error("hold not left at sample service");

  a_motion_cause: assert property (
    $rose(r_reg.motion) |-> $past(svc) && ($past(r_reg.st) == ENG_RUN)
      && $past(r_reg.stable))
    else $error("motion raised while held or unsettled");

  a_dir_latch: assert property (
    r_reg.motion && $past(r_reg.motion)
      && !$past(wr_sc0 && !wd[SC0_MOT]) |-> $stable(r_reg.dir))
    else $error("direction changed while motion latched");

  a_tick_clear: assert property (
    tick_seen |=> !r_reg.tick && housekeep_out)
    else $error("tick not consumed");

  a_blank_window: assert property (
    rate_flip |=> ##1 (blank_active && !detect_active_out) [*3])
    else $error("rate change did not blank detection");

  a_freq_range: assert property (
    r_reg.freq <= FREQ_MAX)
    else $error("frequency response above limit");

  a_enable_readback: assert property (
    wr_en && (avs_address_in == ADDR_ENABLE)
      |=> r_reg.en_code == $past(wd))
    else $error("enable register lost written value");

  a_rsvd_zero: assert property (
    bus_done && avs_read_in && (avs_address_in == ADDR_SC1)
      |-> avs_readdata_out[SC1_RSVD] == 1'b0)
    else $error("reserved bit reads nonzero");

  a_bus_answer: assert property (
    bus_req && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("bus answer late");

endmodule

// ===== testbench/pirms_sensor_model.sv
`timescale 1ns/1ps
module pirms_sensor_model (
  // clock and engine pacing
  input wire logic clk_in,
  input wire logic strobe_in,
  // commands from the bench
  input wire logic arm_a_in,
  input wire logic arm_b_in,
  input wire logic dir_in,
  input wire logic settle_in,
  // detector front end
  output logic motion_a_out,
  output logic motion_b_out,
  output logic motion_dir_out,
  output logic settled_out
);
  logic dir_reg;
  logic flip_reg;

  // an event stays up until the engine has taken a sample after it
  always @(posedge clk_in)
  begin
    flip_reg <= ~flip_reg;
    settled_out <= settle_in;
    if (arm_a_in || arm_b_in)
    begin
      motion_a_out <= arm_a_in;
      motion_b_out <= arm_b_in;
      dir_reg <= dir_in;
    end
    else if (strobe_in)
    begin
      motion_a_out <= 1'b0;
      motion_b_out <= 1'b0;
    end
  end

  // direction only means something with an event, else it wanders
  assign motion_dir_out = (motion_a_out | motion_b_out) ? dir_reg : flip_reg;

  initial
  begin
    flip_reg = 1'b0;
    dir_reg = 1'b0;
    motion_a_out = 1'b0;
    motion_b_out = 1'b0;
    settled_out = 1'b0;
  end
endmodule

// ===== testbench/tb.sv
`timescale 1ns/1ps
module tb
  import pirms_pkg::*;
;
  logic clk_in, resetn, rd_en, wr_en, wait_rq, strobe, hk, act;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic dual, dmode, lowr, emc, pwr, ma, mb, mdir, stl;
  logic arm_a, arm_b, dir, settle;
  logic [1:0] ext, rw;
  logic [3:0] frq;
  logic [7:0] v;
  int bad_count, n_compared, cyc, n;

  //////////////////////////////////////////////////////////////////////
  // clock, design and sensor
  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  pirms_top #(.CONV_CLKS(20), .HOLD_CLKS(100)) i_pirms_top (
    .clk_in(clk_in), .resetn_in(resetn), .avs_address_in(addr),
    .avs_read_in(rd_en), .avs_write_in(wr_en), .avs_writedata_in(wdata),
    .avs_byteenable_in(4'h1), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wait_rq), .motion_a_in(ma), .motion_b_in(mb),
    .motion_dir_in(mdir), .offset_settled_in(stl),
    .sample_strobe_out(strobe), .housekeep_out(hk),
    .detect_active_out(act), .ext_level_out(ext),
    .range_weight_out(rw), .freq_resp_out(frq), .dual_pyro_out(dual),
    .dir_mode_out(dmode), .low_rate_out(lowr), .emc_immune_out(emc),
    .adc_power_out(pwr));

  pirms_sensor_model i_pirms_sensor_model (
    .clk_in(clk_in), .strobe_in(strobe), .arm_a_in(arm_a),
    .arm_b_in(arm_b), .dir_in(dir), .settle_in(settle),
    .motion_a_out(ma), .motion_b_out(mb), .motion_dir_out(mdir),
    .settled_out(stl));

  //////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic chk_reg(input logic [7:0] got, exp, input string m);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, exp, input string m);
    chk_reg({7'h00, got}, {7'h00, exp}, m);
  endtask

  // one bus cycle held until waitrequest is seen low
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= {24'h00_0000, d};
    wr_en <= w;
    rd_en <= ~w;
    do @(posedge clk_in); while (wait_rq !== 1'b0);
    v = rdata[7:0];
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask

  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk_reg(v, e, "register read");
  endtask

  task automatic ws;
    do @(posedge clk_in); while (strobe !== 1'b1);
  endtask

  task automatic arm(input logic a, b, d);
    ws;
    arm_a <= a;
    arm_b <= b;
    dir <= d;
    @(posedge clk_in);
    arm_a <= 1'b0;
    arm_b <= 1'b0;
  endtask

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    rdc(ADDR_ENABLE, ENABLE_RST);
    rdc(ADDR_SC0, 8'h20);
    rdc(ADDR_SC1, 8'h00);
    rdc(12'h3FC, 8'h00);
    chk_reg({6'h00, rw}, 8'h03, "range weight");
    chk_bit(emc, 1'b1, "immunity");
    chk_bit(pwr, 1'b1, "converter power");
    $display("reset values done");
  endtask

  task automatic t_enable;
    bus(1'b1, ADDR_ENABLE, ENGINE_ON_CODE);
    ws;
    rdc(ADDR_SC0, 8'h00);
    rdc(ADDR_ENABLE, 8'h11);
    bus(1'b1, ADDR_ENABLE, 8'h55);
    ws;
    rdc(ADDR_ENABLE, 8'h55);
    rdc(ADDR_SC0, 8'h00);
    bus(1'b1, ADDR_ENABLE, ENGINE_ON_CODE);
    settle <= 1'b1;
    ws;
    ws;
    rdc(ADDR_SC0, 8'h01);
    @(posedge clk_in);
    chk_bit(act, 1'b1, "detect active");
    $display("enable done");
  endtask

  task automatic t_fields;
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, ADDR_SC0, {i[1:0], 6'h02});
      @(posedge clk_in);
      chk_reg({6'h00, ext}, 8'(i), "ext level");
      chk_reg({6'h00, rw}, 8'(3 - i), "range weight");
      rdc(ADDR_SC0, {i[1:0], 6'h01});
    end
    bus(1'b1, ADDR_SC0, 8'h02);
    bus(1'b1, ADDR_SC1, 8'h63);
    rdc(ADDR_SC1, 8'h61);
    chk_bit(dual, 1'b1, "dual mode");
    bus(1'b1, ADDR_SC1, 8'h7A);
    rdc(ADDR_SC1, 8'h60);
    chk_reg({4'h0, frq}, 8'h0C, "freq");
    bus(1'b1, ADDR_SC1, 8'h28);
    $display("fields done");
  endtask

  task automatic t_motion;
    bus(1'b1, ADDR_SC0, 8'h0A);
    arm(1'b1, 1'b0, 1'b1);
    ws;
    rdc(ADDR_SC0, 8'h0F);
    chk_bit(dmode, 1'b1, "direction mode");
    arm(1'b1, 1'b0, 1'b0);
    ws;
    rdc(ADDR_SC0, 8'h0F);
    bus(1'b1, ADDR_SC0, 8'h08);
    bus(1'b0, ADDR_SC0, 8'h00);
    chk_bit(v[SC0_MOT], 1'b0, "motion cleared");
    arm(1'b1, 1'b0, 1'b0);
    ws;
    rdc(ADDR_SC0, 8'h0B);
    bus(1'b1, ADDR_SC0, 8'h00);
    arm(1'b0, 1'b1, 1'b0);
    ws;
    bus(1'b0, ADDR_SC0, 8'h00);
    chk_bit(v[SC0_MOT], 1'b0, "single sensor");
    bus(1'b1, ADDR_SC1, 8'h29);
    arm(1'b0, 1'b1, 1'b1);
    ws;
    rdc(ADDR_SC0, 8'h03);
    bus(1'b1, ADDR_SC1, 8'h28);
    bus(1'b1, ADDR_SC0, 8'h00);
    $display("motion done");
  endtask

  task automatic t_hold;
    bus(1'b1, ADDR_SC0, 8'h10);
    ws;
    @(posedge clk_in);
    chk_bit(act, 1'b0, "held");
    arm(1'b1, 1'b0, 1'b0);
    ws;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (strobe !== 1'b1);
    chk_bit(n == NORM_CLKS, 1'b1, "sample spacing");
    bus(1'b0, ADDR_SC0, 8'h00);
    chk_bit(v[SC0_MOT], 1'b0, "no motion held");
    bus(1'b1, ADDR_SC0, 8'h00);
    ws;
    @(posedge clk_in);
    chk_bit(act, 1'b1, "resumed");
    $display("hold done");
  endtask

  task automatic t_tick;
    bus(1'b1, ADDR_SC1, 8'hA8);
    do @(posedge clk_in); while (hk !== 1'b1);
    rdc(ADDR_SC1, 8'h28);
    $display("tick done");
  endtask

  task automatic t_rate;
    bus(1'b1, ADDR_SC1, 8'h30);
    repeat (3) @(posedge clk_in);
    chk_bit(act, 1'b1, "no blank same rate");
    bus(1'b1, ADDR_SC1, 8'h2C);
    repeat (3) @(posedge clk_in);
    chk_bit(lowr, 1'b1, "low rate");
    chk_bit(emc, 1'b0, "immunity off");
    chk_bit(act, 1'b0, "blanked");
    chk_bit(pwr, 1'b0, "converter off");
    bus(1'b1, ADDR_CONV, 8'h01);
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (strobe !== 1'b1);
    chk_bit(n >= 18 && n <= 24, 1'b1, "shot length");
    chk_bit(act, 1'b0, "still blanked");
    repeat (80) @(posedge clk_in);
    chk_bit(act, 1'b1, "blank over");
    chk_bit(pwr, 1'b0, "converter off");
    bus(1'b1, ADDR_SC1, 8'h28);
    repeat (120) @(posedge clk_in);
    $display("scan rate done");
  endtask

  task automatic t_disable;
    bus(1'b1, ADDR_ENABLE, ENGINE_OFF_CODE);
    ws;
    bus(1'b0, ADDR_SC0, 8'h00);
    chk_bit(v[SC0_DIS], 1'b1, "disabled");
    chk_bit(act, 1'b0, "inactive");
    arm(1'b1, 1'b0, 1'b0);
    ws;
    bus(1'b0, ADDR_SC0, 8'h00);
    chk_bit(v[SC0_MOT], 1'b0, "no motion off");
    $display("disable done");
  endtask

  //////////////////////////////////////////////////////////////////////
  // hang guard and main sequence
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      bad_count++;
      $display("[ERR] %0t timeout", $time);
      results();
    end
  end

  initial
  begin
    bad_count = 0;
    n_compared = 0;
    cyc = 0;
    resetn = 1'b0;
    {rd_en, wr_en, arm_a, arm_b, dir, settle} = 6'h00;
    addr = '0;
    wdata = '0;
    repeat (4) @(posedge clk_in);
    resetn <= 1'b1;
    repeat (4) @(posedge clk_in);
    t_reset();
    t_enable();
    t_fields();
    t_motion();
    t_hold();
    t_tick();
    t_rate();
    t_disable();
    results();
  end
endmodule
